/* File: verification/bde_src_model.sv */
/*
 Configuration bitstream source: offers a counted run of words on the
 valid/ready stream, with optional idle gaps between words.
 Assumes the engine's clock and reset; go is a one-cycle pulse.
*/
`default_nettype none
module bde_src_model
   import bde_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic [7:0]  nwords,
   input  wire logic        slow,
   input  wire logic        cfg_ready,
   output logic [31:0]      cfg_data,
   output logic             cfg_valid,
   output logic [7:0]       taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rem;
   logic [7:0] rn;
   logic [7:0] tn;
   logic       gap;
   assign rn = go ? nwords : rem - 8'(cfg_valid & cfg_ready);
   assign tn = go ? 8'h00 : taken + 8'(cfg_valid & cfg_ready);
   // Words are counted in the chosen bus width unit
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rem       <= 8'h00;
         taken     <= 8'h00;
         gap       <= 1'b0;
         cfg_valid <= 1'b0;
         cfg_data  <= 32'h0000_0000;
      end else begin
         rem   <= rn;
         taken <= tn;
         gap   <= slow & ~gap;
         // An offered word stays put until it is taken
         if (cfg_valid & ~cfg_ready) begin
            cfg_valid <= 1'b1;
         end else if (rn != 8'h00 && !(slow & ~gap)) begin
            cfg_valid <= 1'b1;
            cfg_data  <= {24'ha5c3e1, tn};
         end else begin
            // Idle bus inverts its data each cycle, so the last word returns every second idle cycle
            cfg_valid <= 1'b0;
            cfg_data  <= ~cfg_data;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/bde_top_tb_top.sv */
/*
 Self-checking bench of the decryption engine: APB register tasks and
 stream scenarios against the source model.
 Assumes a 100 MHz clock and zero-wait APB answers.
*/
`default_nettype none
module bde_top_tb_top;
   import bde_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] cfg_data;
   logic        cfg_valid;
   logic        cfg_ready;
   bde_unit_s   mem_out;
   logic        wake;
   logic        init_flag_n;
   logic        auth_fail;
   logic        irq;
   logic        fuse_lock_pin = 1'b0;
   logic        go = 1'b0;
   logic [7:0]  nwords = 8'h00;
   logic        slow = 1'b0;
   logic [7:0]  taken;
   logic [31:0] rd_q;
   logic        err_q;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          n_units = 0;

   always #5 clk = ~clk;

   bde_top bde_top_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
      .mem_out(mem_out), .wake(wake), .init_flag_n(init_flag_n),
      .auth_fail(auth_fail), .irq(irq), .fuse_lock_pin(fuse_lock_pin));

   bde_src_model bde_src_model_inst (.clk(clk), .rst(rst), .go(go),
      .nwords(nwords), .slow(slow), .cfg_ready(cfg_ready),
      .cfg_data(cfg_data), .cfg_valid(cfg_valid), .taken(taken));

   always @(posedge clk) begin
      if (mem_out.valid === 1'b1) n_units++;
   end

   // Ceiling well above the longest scenario
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_q    = prdata;
      err_q   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask

   task automatic stream(input logic [31:0] ctrl, input logic [7:0] n,
                         input logic s);
      logic fin;
      fin = 1'b0;
      do_reset();
      apb(1'b1, A_IV0, 32'h0bad_f00d);
      apb(1'b1, A_IV1, 32'h1357_9bdf);
      apb(1'b1, A_IV2, 32'h2468_ace0);
      apb(1'b1, A_LENU, 32'h1);
      apb(1'b1, A_BLKU, 32'h0);
      apb(1'b1, A_IMASK, 32'hf);
      n_units = 0;
      apb(1'b1, A_CTRL, ctrl);
      nwords <= n;
      slow   <= s;
      go     <= 1'b1;
      @(posedge clk);
      go     <= 1'b0;
      for (int i = 0; i < 300 && !fin; i++) begin
         apb(1'b0, A_STAT, 32'h0);
         fin = |rd_q[4:1];
      end
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, A_STAT, 32'h0);
      check(rd_q, 32'h0, "status after reset");
      apb(1'b0, A_ISTAT, 32'h0);
      check(rd_q, 32'h0, "events after reset");
      apb(1'b0, 8'h40, 32'h0);
      check(32'(err_q), 32'h1, "unmapped read error");
      // Test key store, word by word
      for (int w = 0; w < 8; w++) begin
         apb(1'b1, A_KIDX, 32'h10 + 32'(w));
         apb(1'b1, A_KDATA, 32'h1111_0000 + 32'(w));
      end
      apb(1'b1, A_KIDX, 32'h13);
      apb(1'b0, A_KDATA, 32'h0);
      check(rd_q, 32'h1111_0003, "key word readback");
      apb(1'b1, A_CTRL, 32'h100);
      apb(1'b0, A_KDATA, 32'h0);
      check(rd_q, 32'h0, "protected key data");
      check(32'(err_q), 32'h1, "protected key error");
      apb(1'b0, A_STAT, 32'h0);
      check(32'(rd_q[6]), 32'h1, "protect status");
      // Fuse store lock by register, then by pin across reset
      apb(1'b1, A_CTRL, 32'h200);
      apb(1'b1, A_KIDX, 32'h0);
      apb(1'b1, A_KDATA, 32'hdead_0001);
      check(32'(err_q), 32'h1, "locked fuse write");
      fuse_lock_pin <= 1'b1;
      do_reset();
      repeat (4) @(posedge clk);
      apb(1'b0, A_STAT, 32'h0);
      check(32'(rd_q[5]), 32'h1, "pin lock held");
      apb(1'b1, A_KIDX, 32'h0);
      apb(1'b1, A_KDATA, 32'hdead_0002);
      check(32'(err_q), 32'h1, "pin locked write");
      fuse_lock_pin <= 1'b0;
      // Block mode on a compressed stream, masked then unmasked
      do_reset();
      apb(1'b1, A_IMASK, 32'h0);
      apb(1'b1, A_CTRL, 32'h29);
      apb(1'b0, A_STAT, 32'h0);
      check(32'(rd_q[4]), 32'h1, "mode error status");
      check(32'(irq), 32'h0, "masked irq");
      apb(1'b1, A_IMASK, 32'h8);
      @(posedge clk);
      check(32'(irq), 32'h1, "unmasked irq");
      apb(1'b0, A_ISTAT, 32'h0);
      check(rd_q, 32'h8, "mode error event");
      @(posedge clk);
      check(32'(irq), 32'h0, "irq after clear");
      // Wrong key, byte-wide bus: exactly one unit is gathered
      stream(32'h05, 8'd20, 1'b0);
      check(32'(taken), 32'd16, "x8 words per unit");
      check(32'(rd_q[3]), 32'h1, "wrong key status");
      check(32'(wake), 32'h0, "no wake on wrong key");
      check(32'(init_flag_n), 32'h0, "init flag wrong key");
      check(32'(n_units), 32'h0, "check unit withheld");
      check(32'(irq), 32'h1, "wrong key irq");
      // Self-authenticated stream on a word-wide bus with a slow source
      stream(32'h95, 8'd8, 1'b1);
      check(32'(taken), 32'd8, "x32 words taken");
      check(32'(n_units), 32'h1, "data unit out");
      check(32'(wake), 32'h0, "no wake on bad tag");
      check(32'(auth_fail), 32'h1, "auth fail flag");
      check(32'(init_flag_n), 32'h0, "init flag low");
      apb(1'b0, A_ISTAT, 32'h0);
      check(32'(rd_q[1]), 32'h1, "auth event");
      // Block mode with zero block size keeps the stream as one block
      stream(32'h9d, 8'd8, 1'b0);
      check(32'(rd_q[4]), 32'h0, "block mode accepted");
      check(32'(taken), 32'd8, "block mode words taken");
      check(32'(n_units), 32'h1, "single block data out");
      summarize();
   end
endmodule
`default_nettype wire

/* File: verilog/bde_core.sv */
/*
 Iterated block transform: 128-bit input, 256-bit key, fixed round count.
 Assumes start is only raised while the core is idle.
*/
`default_nettype none
module bde_core
   import bde_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [255:0] key,
   input  wire logic [127:0] din,
   output logic [127:0]      dout,
   output logic              vld
);
   typedef struct packed {
      logic         busy;
      logic [3:0]   rnd;
      logic [127:0] s;
      logic [127:0] dout;
      logic         vld;
   } bde_core_s;
   bde_core_s r, n;

   always_comb begin
      n = r;
      n.vld = 1'b0;
      if (start) begin
         n.busy = 1'b1;
         n.rnd = '0;
         n.s = din;
      end else if (r.busy) begin
         n.s = bde_mix(r.s, r.rnd[0] ? key[255:128] : key[127:0]);
         n.rnd = r.rnd + 4'h1;
         if (r.rnd == ROUNDS - 4'h1) begin
            n.busy = 1'b0;
            n.dout = n.s;
            n.vld = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign dout = r.dout;
   assign vld  = r.vld;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   core_latency_a: assert property (start |-> ##15 vld)
      else $error("Cipher result not ready after the round count");
endmodule
`default_nettype wire

/* File: verilog/bde_kmem.sv */
/*
 Key store memory: fuse, battery-backed and test key words, 8 words each.
 Assumes the caller enforces write locks; read data is registered.
*/
`default_nettype none
module bde_kmem
   import bde_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        we,
   input  wire logic [4:0]  waddr,
   input  wire logic [31:0] wdata,
   input  wire logic [4:0]  raddr,
   output logic [31:0]      rdata
);
   // Array holds no reset: it models non-volatile and retained storage
   logic [31:0] mem [32];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

/* File: verilog/bde_pkg.sv */
/*
 Shared constants, types and helper functions of the bitstream
 decryption engine. Assumes one 100 MHz configuration clock.
*/
`default_nettype none
package bde_pkg;
   // APB register byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_ISTAT = 8'h08;
   localparam logic [7:0] A_IMASK = 8'h0c;
   localparam logic [7:0] A_BLKU  = 8'h10;
   localparam logic [7:0] A_LENU  = 8'h14;
   localparam logic [7:0] A_KIDX  = 8'h18;
   localparam logic [7:0] A_KDATA = 8'h1c;
   localparam logic [7:0] A_IV0   = 8'h20;
   localparam logic [7:0] A_IV1   = 8'h24;
   localparam logic [7:0] A_IV2   = 8'h28;
   // Control field positions
   localparam int C_START = 0;
   localparam int C_SRC   = 1;
   localparam int C_BLK   = 3;
   localparam int C_AUTH  = 4;
   localparam int C_COMP  = 5;
   localparam int C_WID   = 6;
   localparam int C_RDPR  = 8;
   localparam int C_FLOCK = 9;
   // Interrupt / event bits
   localparam int E_DONE = 0;
   localparam int E_AUTH = 1;
   localparam int E_KBAD = 2;
   localparam int E_MODE = 3;
   localparam logic [1:0] SRC_FUSE = 2'h0;
   localparam logic [1:0] SRC_BATT = 2'h1;
   localparam logic [1:0] SRC_TEST = 2'h2;
   localparam logic [1:0] W8  = 2'h0;
   localparam logic [1:0] W16 = 2'h1;
   localparam logic [7:0] UNIT_BITS = 8'h80;
   localparam int FRAME_GRP_BITS = 413696;
   localparam logic [31:0] UNITS_PER_GRP = 32'(FRAME_GRP_BITS / 128);
   localparam logic [3:0] ROUNDS = 4'he;
   localparam logic [3:0] KEY_WORDS = 4'h8;
   localparam logic [31:0] CTR_J0    = 32'h1;
   localparam logic [31:0] CTR_FIRST = 32'h2;
   // Check unit expected first when no tag is carried; arbitrary value
   localparam logic [127:0] KEY_CHECK = 128'h5a5a_c3c3_0ff0_a55a_1234_5678_9abc_def0;

   typedef enum logic [2:0] {
      ST_IDLE, ST_KEYLD, ST_J0, ST_GATH, ST_CIPH, ST_TAG, ST_DONE, ST_FAIL
   } bde_st_e;

   typedef struct packed {
      logic [127:0] data;
      logic         valid;
   } bde_unit_s;

   function automatic logic [127:0] bde_mix(input logic [127:0] s,
                                           input logic [127:0] rk);
      logic [127:0] t;
      t = s ^ rk;
      bde_mix = {t[114:0], t[127:115]} ^ {t[63:0], t[127:64]}
                ^ {t[31:0] + t[95:64], t[127:96], t[63:32], t[95:64]};
   endfunction

   function automatic logic [127:0] bde_gather(input logic [127:0] a,
                                              input logic [31:0] d,
                                              input logic [1:0] w);
      unique case (w)
         W8:      bde_gather = {a[119:0], d[7:0]};
         W16:     bde_gather = {a[111:0], d[15:0]};
         default: bde_gather = {a[95:0], d};
      endcase
   endfunction

   function automatic logic [7:0] bde_wbits(input logic [1:0] w);
      unique case (w)
         W8:      bde_wbits = 8'h08;
         W16:     bde_wbits = 8'h10;
         default: bde_wbits = 8'h20;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: verilog/bde_top.sv */
/*
 Bitstream decryption engine: APB registers, key stores, stream gather,
 counter-mode decryption, chained block keys and tag check.
 Assumes configuration words arrive on this clock with valid/ready.
*/
// The register addresses and the APB slave port were decided locally.
`default_nettype none
module bde_top
   import bde_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] cfg_data,
   input  wire logic        cfg_valid,
   output logic             cfg_ready,
   output bde_unit_s        mem_out,
   output logic             wake,
   output logic             init_flag_n,
   output logic             auth_fail,
   output logic             irq,
   input  wire logic        fuse_lock_pin
);
   typedef struct packed {
      bde_st_e      st;
      logic [1:0]   src;
      logic         blk;
      logic         auth;
      logic         comp;
      logic [1:0]   wid;
      logic         rdprot;
      logic         flock;
      logic [1:0]   lsync;
      logic         done;
      logic         afail;
      logic         kbad;
      logic         merr;
      logic [3:0]   ist;
      logic [3:0]   imsk;
      logic [15:0]  blku;
      logic [23:0]  lenu;
      logic [4:0]   kidx;
      logic [95:0]  iv;
      logic [255:0] key;
      logic [255:0] nkey;
      logic [3:0]   kcnt;
      logic [127:0] acc;
      logic [7:0]   abits;
      logic [31:0]  ctr;
      logic [23:0]  ucnt;
      logic [31:0]  bcnt;
      logic [127:0] ct;
      logic [127:0] tagacc;
      logic [127:0] ekj0;
      logic         first;
      bde_unit_s    mo;
      logic [31:0]  prd;
      logic         perr;
      logic         pkey;
   } bde_state_s;
   bde_state_s r, n;

   logic         setup;
   logic         acc;
   logic         busy;
   logic         cst;
   logic [127:0] cdin;
   logic [127:0] cout;
   logic         cvld;
   logic         ks_we;
   logic [4:0]   ks_ra;
   logic [31:0]  ks_rd;
   logic [3:0]   ev;
   logic [31:0]  blksz;
   logic [127:0] pt;
   logic         kload;

   bde_core bde_core_inst (
      .clk   (clk),
      .rst   (rst),
      .start (cst),
      .key   (r.key),
      .din   (cdin),
      .dout  (cout),
      .vld   (cvld)
   );

   bde_kmem bde_kmem_inst (
      .clk   (clk),
      .rst   (rst),
      .we    (ks_we),
      .waddr (r.kidx),
      .wdata (pwdata),
      .raddr (ks_ra),
      .rdata (ks_rd)
   );

   assign setup = psel & ~penable;
   assign acc   = psel & penable;
   assign busy  = (r.st != ST_IDLE) && (r.st != ST_DONE)
                  && (r.st != ST_FAIL);
   // Groups of 128 frames, expressed in 128-bit units
   assign blksz = 32'(r.blku) * UNITS_PER_GRP;
   assign pt    = r.ct ^ cout;
   assign kload = (r.st == ST_KEYLD);
   // During a key load the engine owns the store read port
   assign ks_ra = kload ? {r.src, r.kcnt[2:0]} : r.kidx;
   // Fuse words are refused once locked; no key writes while running
   assign ks_we = acc & pwrite & (paddr == A_KDATA) & ~busy
                  & ~(r.kidx[4:3] == SRC_FUSE && r.flock);

   always_comb begin
      n = r;
      n.mo.valid = 1'b0;
      ev = '0;
      cst = 1'b0;
      cdin = {r.iv, r.ctr};
      cfg_ready = 1'b0;
      n.lsync = {r.lsync[0], fuse_lock_pin};
      if (r.lsync[1]) begin
         n.flock = 1'b1;
      end
      // Register reads sampled in the setup phase
      if (setup) begin
         n.pkey = 1'b0;
         n.perr = 1'b0;
         n.prd = '0;
         unique case (paddr)
            A_CTRL:  n.prd = {22'h0, r.flock, r.rdprot, r.wid, r.comp,
                              r.auth, r.blk, r.src, 1'b0};
            A_STAT:  n.prd = {25'h0, r.rdprot, r.flock, r.merr, r.kbad,
                              r.afail, r.done, busy};
            A_ISTAT: n.prd = {28'h0, r.ist};
            A_IMASK: n.prd = {28'h0, r.imsk};
            A_BLKU:  n.prd = {16'h0, r.blku};
            A_LENU:  n.prd = {8'h0, r.lenu};
            A_KIDX:  n.prd = {27'h0, r.kidx};
            A_KDATA: begin
               n.pkey = ~pwrite & ~r.rdprot & ~busy;
               n.perr = ~pwrite & (r.rdprot | busy);
            end
            A_IV0:   n.prd = r.iv[31:0];
            A_IV1:   n.prd = r.iv[63:32];
            A_IV2:   n.prd = r.iv[95:64];
            default: n.perr = 1'b1;
         endcase
         if (pwrite && paddr == A_KDATA) begin
            n.perr = busy | (r.kidx[4:3] == SRC_FUSE && r.flock);
         end
      end
      if (acc && pwrite && !busy) begin
         unique case (paddr)
            A_CTRL: begin
               n.src  = pwdata[C_SRC +: 2];
               n.blk  = pwdata[C_BLK];
               n.auth = pwdata[C_AUTH];
               n.comp = pwdata[C_COMP];
               n.wid  = pwdata[C_WID +: 2];
               // Both bits can only be set; reset alone clears protection
               n.rdprot = r.rdprot | pwdata[C_RDPR];
               n.flock  = n.flock | pwdata[C_FLOCK];
            end
            A_BLKU: n.blku = pwdata[15:0];
            A_LENU: n.lenu = pwdata[23:0];
            A_KIDX: n.kidx = pwdata[4:0];
            A_IV0:  n.iv[31:0] = pwdata;
            A_IV1:  n.iv[63:32] = pwdata;
            A_IV2:  n.iv[95:64] = pwdata;
            default: ;
         endcase
      end
      if (acc && pwrite && paddr == A_IMASK) begin
         n.imsk = pwdata[3:0];
      end
      unique case (r.st)
         ST_IDLE, ST_DONE, ST_FAIL: begin
            if (acc && pwrite && paddr == A_CTRL && pwdata[C_START]) begin
               n.done = 1'b0;
               n.afail = 1'b0;
               n.kbad = 1'b0;
               n.merr = 1'b0;
               if (pwdata[C_COMP] && pwdata[C_BLK]) begin
                  n.merr = 1'b1;
                  ev[E_MODE] = 1'b1;
                  n.st = ST_IDLE;
               end else begin
                  n.kcnt = '0;
                  n.st = ST_KEYLD;
               end
            end
         end
         ST_KEYLD: begin
            // Store word k arrives one cycle after its address
            n.kcnt = r.kcnt + 4'h1;
            if (r.kcnt != 4'h0) begin
               // Word index kept to three bits so the slice stays in range
               n.key[{3'(r.kcnt - 4'h1), 5'h00} +: 32] = ks_rd;
            end
            if (r.kcnt == KEY_WORDS) begin
               cst = 1'b1;
               cdin = {r.iv, CTR_J0};
               n.st = ST_J0;
            end
         end
         ST_J0: begin
            if (cvld) begin
               n.ekj0 = cout;
               n.ctr = CTR_FIRST;
               n.ucnt = '0;
               n.bcnt = '0;
               n.abits = '0;
               n.tagacc = '0;
               n.first = 1'b1;
               n.st = ST_GATH;
            end
         end
         ST_GATH: begin
            cfg_ready = 1'b1;
            if (cfg_valid) begin
               n.acc = bde_gather(r.acc, cfg_data, r.wid);
               n.abits = r.abits + bde_wbits(r.wid);
               if (n.abits == UNIT_BITS) begin
                  n.abits = '0;
                  n.ct = n.acc;
                  if (r.ucnt == r.lenu) begin
                     n.st = ST_TAG;
                  end else begin
                     cst = 1'b1;
                     cdin = {r.iv, r.ctr};
                     n.st = ST_CIPH;
                  end
               end
            end
         end
         ST_CIPH: begin
            if (cvld) begin
               n.ctr = r.ctr + 32'h1;
               n.ucnt = r.ucnt + 24'h1;
               n.bcnt = r.bcnt + 32'h1;
               n.first = 1'b0;
               n.tagacc = bde_mix(r.tagacc, r.ct);
               n.st = ST_GATH;
               if (r.first && !r.auth) begin
                  if (pt != KEY_CHECK) begin
                     n.kbad = 1'b1;
                     ev[E_KBAD] = 1'b1;
                     n.st = ST_FAIL;
                  end
               end else if (r.blk && r.blku != 16'h0
                            && r.bcnt >= blksz - 32'h2) begin
                  // Last two units of a block carry the next block key
                  if (r.bcnt == blksz - 32'h2) begin
                     n.nkey[127:0] = pt;
                  end else begin
                     n.key = {pt, r.nkey[127:0]};
                     n.bcnt = '0;
                  end
               end else begin
                  n.mo.data = pt;
                  n.mo.valid = 1'b1;
               end
            end
         end
         ST_TAG: begin
            if (r.auth && r.ct != (r.tagacc ^ r.ekj0)) begin
               n.afail = 1'b1;
               ev[E_AUTH] = 1'b1;
               n.st = ST_FAIL;
            end else if (!r.auth && r.first) begin
               // No check unit was seen, so the key is unproven
               n.kbad = 1'b1;
               ev[E_KBAD] = 1'b1;
               n.st = ST_FAIL;
            end else begin
               n.done = 1'b1;
               ev[E_DONE] = 1'b1;
               n.st = ST_DONE;
            end
         end
      endcase
      // Read clears status, but an event in the same cycle still lands
      if (acc && !pwrite && paddr == A_ISTAT) begin
         n.ist = '0;
      end
      n.ist = n.ist | ev;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign pready      = 1'b1;
   assign pslverr     = acc & r.perr;
   assign prdata      = r.pkey ? ks_rd : r.prd;
   assign mem_out     = r.mo;
   assign wake        = r.done;
   assign auth_fail   = r.afail;
   assign init_flag_n = ~(r.afail | r.kbad);
   assign irq         = |(r.ist & r.imsk);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   fuse_write_lock_a: assert property (
      acc && pwrite && paddr == A_KDATA
      && r.kidx[4:3] == SRC_FUSE && r.flock |-> !ks_we && pslverr)
      else $error("Locked fuse store was written");
   key_read_prot_a: assert property (
      acc && !pwrite && paddr == A_KDATA && r.rdprot
      |-> prdata == 32'h0 && pslverr)
      else $error("Protected key value was readable");
   bad_key_wake_a: assert property (
      r.kbad |-> !wake && r.st != ST_DONE)
      else $error("Wake-up despite wrong key");
   comp_block_refuse_a: assert property (
      acc && pwrite && paddr == A_CTRL && !busy && pwdata[C_START]
      && pwdata[C_COMP] && pwdata[C_BLK]
      |=> r.merr && r.st == ST_IDLE && r.ist[E_MODE])
      else $error("Compressed block-mode stream not refused");
   block_key_chain_a: assert property (
      r.st == ST_CIPH && cvld && r.blk && r.blku != 16'h0
      && !r.first && r.bcnt == blksz - 32'h1
      |=> r.bcnt == 32'h0 && r.key[255:128] == $past(pt)
          && !mem_out.valid)
      else $error("Block key not taken from preceding block");
   auth_gate_a: assert property (
      r.st == ST_TAG && r.auth && r.ct != (r.tagacc ^ r.ekj0)
      |=> !wake && auth_fail ##1 !wake)
      else $error("Failed tag did not block wake-up");
   auth_flag_pin_a: assert property (
      auth_fail |-> !init_flag_n)
      else $error("Init flag high during authentication failure");
   unit_gather_a: assert property (
      r.st == ST_GATH && cfg_valid && r.wid == W8
      && r.abits == UNIT_BITS - 8'h08
      |=> r.abits == 8'h0 && r.ct[7:0] == $past(cfg_data[7:0])
          && (r.st == ST_CIPH || r.st == ST_TAG))
      else $error("Unit not formed from gathered bus words");
   ist_set_wins_a: assert property (
      |ev |=> (r.ist & $past(ev)) == $past(ev))
      else $error("Event lost against status clear");
endmodule
`default_nettype wire
